// File: afc_pkg.sv
package afc_pkg;
    // register indices on the plain port (byte offsets are not used here)
    localparam logic [1:0] ADDR_FLAGS = 2'h0;
    localparam logic [1:0] ADDR_CTRL = 2'h1;
    localparam logic [1:0] ADDR_SHIFT = 2'h2;
    // condition flag bit positions
    localparam int F_NEG_R = 15;
    localparam int F_NEG_I = 14;
    localparam int F_CARRY_R = 13;
    localparam int F_CARRY_I = 12;
    localparam int F_ZERO = 11;
    localparam int F_OVF = 10;
    localparam int F_STICKY = 9;
    localparam int F_EARLY = 8;
    localparam int F_MULT = 7;
    localparam int F_EMPTY = 6;
    // control bit positions
    localparam int C_IMAG_HOLD = 15;
    localparam int C_REAL_HOLD = 14;
    localparam int C_MIN_EXP = 13;
    localparam int C_MODE_LO = 8;
    localparam int C_IN_HOLD = 7;
    localparam int C_M_SIGNED = 6;
    localparam int C_N_SIGNED = 5;
    localparam int C_CONJ = 4;
    localparam int C_CLAMP = 3;
    localparam int C_ACC_SEL = 2;
    localparam int C_WIDTH_SEL = 1;
    localparam int C_RDELAY = 0;
    localparam logic [15:0] CTRL_WMASK = 16'he3ff;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0040;
    localparam int MSB32 = 31;
    localparam int HALF_HI = 30;
    localparam int MSB16 = 15;
    localparam int BUS_W = 24;
    localparam int SHIFT_W = 5;
    localparam logic [4:0] SHIFT_RESET = 5'h1f;

    typedef enum logic [1:0] {
        AFC_MODE_REAL = 2'h0,
        AFC_MODE_COMPLEX_MODE = 2'h1,
        AFC_MODE_DOUBLE_PRECISION_MODE = 2'h2
    } afc_mode_t;

    typedef struct packed {
        logic valid;
        logic arith;
        logic [31:0] real_res;
        logic [31:0] imag_res;
        logic carry_r;
        logic carry_i;
        logic ovf_r;
        logic ovf_i;
    } afc_alu_t;

    typedef struct packed {
        logic imag_hold;
        logic real_hold;
        logic in_hold;
        logic m_signed;
        logic n_signed;
        logic conj;
        logic clamp;
        logic acc_second;
        logic width_msb24;
        logic rdelay_sel;
    } afc_ctrl_t;
endpackage

// File: afc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - flag 15 follows msb of alu result
// - in complex mode flag 14 follows imaginary result msb
// - flag 13 holds carry out of result msb
// - flag 12 holds complex imaginary carry out
// - flag 11 set on zero result; complex needs both parts zero
// - flag 10 set on overflow; complex uses either part
// - flag 9 sticky overflow, cleared when a branch tests it
// - flag 8 latches bit30 xor bit31, cleared by branch test
// - flag 7 latches complex multiplier overflow, cleared by load-flags op
// - flag 6 shows fifo empty; bits 5..0 read zero
// - control bit 15 holds imaginary product under interrupt
// - control bit 14 holds real product under interrupt
// - control bit 7 holds multiplier inputs under interrupt
// - control bit 13 makes shift register keep smallest exponent
// - control bit 2 picks first or second accumulator of pairs
// - control bit 1 picks 24 msb or 16 lsb onto data path
// - data buses and transfer register are 24 bits wide
// - control bit 0 picks right delay register as alu right input
// - two-bit mode field selects real, complex or double precision
// - accumulator select acts only in real and double modes
// - every flag bit is offered to the sequencer for branches
module afc_top #(
    parameter int DATA_W = afc_pkg::BUS_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire afc_pkg::afc_alu_t alu_in,
    input wire logic mult_ovf,
    input wire logic fifo_empty,
    input wire logic branch_test_sticky,
    input wire logic branch_test_early,
    input wire logic load_flags_op,
    input wire logic [15:0] load_flags_val,
    input wire logic shift_load,
    input wire logic [afc_pkg::SHIFT_W-1:0] shift_load_val,
    input wire logic irq_active,
    input wire logic [31:0] result_word,
    output logic [15:0] branch_flags,
    output afc_pkg::afc_ctrl_t ctrl_out,
    output logic [1:0] mode_out,
    output logic hold_imag_product,
    output logic hold_real_product,
    output logic hold_mult_inputs,
    output logic acc_pair_second,
    output logic [DATA_W-1:0] data_path_out,
    output logic [afc_pkg::SHIFT_W-1:0] shift_amount_reg
);
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [4:0] shift_next;
    logic [15:0] rdata_next;
    logic [DATA_W-1:0] data_next;

    wire afc_pkg::afc_mode_t mode_w =
        afc_pkg::afc_mode_t'(ctrl_reg[afc_pkg::C_MODE_LO +: 2]);
    wire is_complex_mode = (mode_w == afc_pkg::AFC_MODE_COMPLEX_MODE);
    wire ctrl_wr = reg_wr && (reg_addr == afc_pkg::ADDR_CTRL);
    wire flags_wr = reg_wr && (reg_addr == afc_pkg::ADDR_FLAGS);
    wire shift_wr = reg_wr && (reg_addr == afc_pkg::ADDR_SHIFT);

    // zero test per part: complex uses 16-bit halves
    function automatic logic part_zero(input logic [31:0] v,
                                       input logic complex_mode);
        part_zero = complex_mode ? (v[afc_pkg::MSB16:0] == 16'h0000)
                         : (v == 32'h0000_0000);
    endfunction

    wire [4:0] msb_pos = is_complex_mode ? 5'(afc_pkg::MSB16) : 5'(afc_pkg::MSB32);
    wire neg_r = alu_in.real_res[msb_pos];
    wire neg_i = is_complex_mode && alu_in.imag_res[msb_pos];
    wire zero_w = part_zero(alu_in.real_res, is_complex_mode) &&
                  (!is_complex_mode || part_zero(alu_in.imag_res, is_complex_mode));
    wire ovf_w = alu_in.arith &&
                 (alu_in.ovf_r || (is_complex_mode && alu_in.ovf_i));
    wire early_w = alu_in.arith &&
                   (alu_in.real_res[afc_pkg::HALF_HI] ^
                    alu_in.real_res[afc_pkg::MSB32]);

    always_comb begin
        flags_next = flags_reg;
        if (alu_in.valid) begin
            flags_next[afc_pkg::F_NEG_R] = neg_r;
            flags_next[afc_pkg::F_NEG_I] = neg_i;
            flags_next[afc_pkg::F_CARRY_R] = alu_in.carry_r;
            flags_next[afc_pkg::F_CARRY_I] = is_complex_mode && alu_in.carry_i;
            flags_next[afc_pkg::F_ZERO] = zero_w;
            flags_next[afc_pkg::F_OVF] = ovf_w;
        end
        // sticky overflow, set wins over branch clear
        if (alu_in.valid && ovf_w) begin
            flags_next[afc_pkg::F_STICKY] = 1'b1;
        end else if (branch_test_sticky) begin
            flags_next[afc_pkg::F_STICKY] = 1'b0;
        end
        if (alu_in.valid && early_w) begin
            flags_next[afc_pkg::F_EARLY] = 1'b1;
        end else if (branch_test_early) begin
            flags_next[afc_pkg::F_EARLY] = 1'b0;
        end
        // multiplier overflow, cleared only by load-flags op or a flags register write
        if (mult_ovf && is_complex_mode) begin
            flags_next[afc_pkg::F_MULT] = 1'b1;
        end else if (load_flags_op) begin
            flags_next[afc_pkg::F_MULT] = load_flags_val[afc_pkg::F_MULT];
        end
        if (load_flags_op && !alu_in.valid) begin
            flags_next[15:10] = load_flags_val[15:10];
        end
        if (flags_wr && !(mult_ovf && is_complex_mode)) begin
            flags_next[afc_pkg::F_MULT] = reg_wdata[afc_pkg::F_MULT];
        end
        flags_next[afc_pkg::F_EMPTY] = fifo_empty;
        flags_next[5:0] = 6'h00;
    end

    wire [15:0] ctrl_w = reg_wdata & afc_pkg::CTRL_WMASK;
    // mode code 3 is not defined, so it is refused and old mode kept
    wire mode_bad = (ctrl_w[afc_pkg::C_MODE_LO +: 2] == 2'h3);
    assign ctrl_next = !ctrl_wr ? ctrl_reg :
        mode_bad ? {ctrl_w[15:10], ctrl_reg[9:8], ctrl_w[7:0]} : ctrl_w;

    wire shift_take = shift_load &&
        (!ctrl_reg[afc_pkg::C_MIN_EXP] || shift_load_val < shift_amount_reg);
    assign shift_next = shift_wr ? reg_wdata[4:0] :
                        shift_take ? shift_load_val : shift_amount_reg;

    assign rdata_next =
        (reg_addr == afc_pkg::ADDR_FLAGS) ? flags_reg :
        (reg_addr == afc_pkg::ADDR_CTRL) ? ctrl_reg :
        (reg_addr == afc_pkg::ADDR_SHIFT) ? {11'h000, shift_amount_reg} :
        16'h0000;

    assign data_next = ctrl_reg[afc_pkg::C_WIDTH_SEL] ?
        DATA_W'(result_word[afc_pkg::MSB32 -: DATA_W]) :
        DATA_W'(result_word[afc_pkg::MSB16:0]);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_reg <= afc_pkg::FLAGS_RESET;
            ctrl_reg <= afc_pkg::CTRL_RESET;
            shift_amount_reg <= afc_pkg::SHIFT_RESET;
        end else begin
            flags_reg <= flags_next;
            ctrl_reg <= ctrl_next;
            shift_amount_reg <= shift_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            data_path_out <= '0;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : 16'h0000;
            data_path_out <= data_next;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            branch_flags <= afc_pkg::FLAGS_RESET;
        end else begin
            branch_flags <= flags_next;
        end
    end

    wire acc_w = ctrl_next[afc_pkg::C_ACC_SEL] &&
        (ctrl_next[afc_pkg::C_MODE_LO +: 2] != 2'(afc_pkg::AFC_MODE_COMPLEX_MODE));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_imag_product <= 1'b0;
            hold_real_product <= 1'b0;
            hold_mult_inputs <= 1'b0;
            acc_pair_second <= 1'b0;
            mode_out <= 2'h0;
            ctrl_out <= '0;
        end else begin
            hold_imag_product <= irq_active &&
                ctrl_next[afc_pkg::C_IMAG_HOLD];
            hold_real_product <= irq_active &&
                ctrl_next[afc_pkg::C_REAL_HOLD];
            hold_mult_inputs <= irq_active && ctrl_next[afc_pkg::C_IN_HOLD];
            // accumulator pair only in real and double
            acc_pair_second <= acc_w;
            mode_out <= ctrl_next[afc_pkg::C_MODE_LO +: 2];
            ctrl_out <= '{imag_hold: ctrl_next[afc_pkg::C_IMAG_HOLD],
                          real_hold: ctrl_next[afc_pkg::C_REAL_HOLD],
                          in_hold: ctrl_next[afc_pkg::C_IN_HOLD],
                          m_signed: ctrl_next[afc_pkg::C_M_SIGNED],
                          n_signed: ctrl_next[afc_pkg::C_N_SIGNED],
                          conj: ctrl_next[afc_pkg::C_CONJ],
                          clamp: ctrl_next[afc_pkg::C_CLAMP],
                          acc_second: acc_w,
                          width_msb24: ctrl_next[afc_pkg::C_WIDTH_SEL],
                          rdelay_sel: ctrl_next[afc_pkg::C_RDELAY]};
        end
    end

    sticky_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        (alu_in.valid && ovf_w) |=> flags_reg[afc_pkg::F_STICKY])
        else $error("sticky overflow not set");
    sticky_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (flags_reg[afc_pkg::F_STICKY] && !branch_test_sticky)
        |=> flags_reg[afc_pkg::F_STICKY])
        else $error("sticky overflow lost");
    mult_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
        (flags_reg[afc_pkg::F_MULT] && !load_flags_op && !flags_wr)
        |=> flags_reg[afc_pkg::F_MULT])
        else $error("multiplier overflow lost");
    empty_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 flags_reg[afc_pkg::F_EMPTY] == $past(fifo_empty))
        else $error("empty flag wrong");
    flags_resv_a: assert property (@(posedge ref_clk) disable iff (rst)
        flags_reg[5:0] == 6'h00)
        else $error("reserved flags nonzero");
    ctrl_resv_a: assert property (@(posedge ref_clk) disable iff (rst)
        ctrl_reg[12:10] == 3'h0)
        else $error("reserved control nonzero");
    acc_complex_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
        (mode_out == 2'(afc_pkg::AFC_MODE_COMPLEX_MODE)) |-> !acc_pair_second)
        else $error("pair select in complex mode");
    min_exp_a: assert property (@(posedge ref_clk) disable iff (rst)
        (ctrl_reg[afc_pkg::C_MIN_EXP] && !shift_wr)
        |=> shift_amount_reg <= $past(shift_amount_reg))
        else $error("shift amount grew");
    sign_real_a: assert property (@(posedge ref_clk) disable iff (rst)
        (alu_in.valid && !is_complex_mode) |=>
        flags_reg[afc_pkg::F_NEG_R] == $past(alu_in.real_res[31]))
        else $error("real sign wrong");
endmodule

// File: afc_seq_model.sv
`timescale 1ns/1ps
module afc_seq_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] branch_flags,
    input wire logic test_sticky,
    input wire logic test_early,
    output logic branch_test_sticky,
    output logic branch_test_early,
    output logic taken
);
    // branch samples flag, then clears it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            branch_test_sticky <= 1'b0;
            branch_test_early <= 1'b0;
            taken <= 1'b0;
        end else begin
            branch_test_sticky <= test_sticky;
            branch_test_early <= test_early;
            if (test_sticky | test_early) begin
                taken <= test_sticky ? branch_flags[afc_pkg::F_STICKY]
                                     : branch_flags[afc_pkg::F_EARLY];
            end
        end
    end
endmodule

// File: arith_flags_and_control_bench.sv
`timescale 1ns/1ps
module arith_flags_and_control_bench;
    typedef struct packed {
        logic [15:0] e;
        logic [15:0] m;
    } afc_note_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    afc_pkg::afc_alu_t alu_in = '0;
    logic mult_ovf = 1'b0;
    logic fifo_empty = 1'b1;
    logic load_flags_op = 1'b0;
    logic [15:0] load_flags_val = 16'h0000;
    logic shift_load = 1'b0;
    logic [4:0] shift_load_val = 5'h00;
    logic irq_active = 1'b0;
    logic [31:0] result_word = 32'h0000_0000;
    logic test_sticky = 1'b0;
    logic test_early = 1'b0;
    logic branch_test_sticky, branch_test_early, taken;
    logic [15:0] branch_flags;
    afc_pkg::afc_ctrl_t ctrl_out;
    logic [1:0] mode_out;
    logic hold_imag_product, hold_real_product, hold_mult_inputs;
    logic acc_pair_second;
    logic [23:0] data_path_out;
    logic [4:0] shift_amount_reg;
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'ha11f_55e3;
    logic [15:0] v;
    int fails = 0;
    int checks = 0;
    afc_note_t notes[$];
    afc_note_t n;
    afc_top afc_top_i (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .alu_in, .mult_ovf, .fifo_empty,
        .branch_test_sticky, .branch_test_early, .load_flags_op,
        .load_flags_val, .shift_load, .shift_load_val, .irq_active,
        .result_word, .branch_flags, .ctrl_out, .mode_out,
        .hold_imag_product, .hold_real_product, .hold_mult_inputs,
        .acc_pair_second, .data_path_out, .shift_amount_reg);
    afc_seq_model afc_seq_model_i (.ref_clk, .rst, .branch_flags,
        .test_sticky, .test_early, .branch_test_sticky,
        .branch_test_early, .taken);
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // strobe tasks keep a gap cycle so no signal is set twice per step
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [1:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        reg_addr <= a;
        reg_rd <= 1'b1;
        notes.push_back('{e, m});
        cyc(1);
        reg_rd <= 1'b0;
        cyc(1);
    endtask
    task automatic alu(input logic [31:0] r, input logic [31:0] i,
                       input logic [3:0] f);
        alu_in <= '{1'b1, 1'b1, r, i, f[3], f[2], f[1], f[0]};
        cyc(1);
        alu_in.valid <= 1'b0;
        cyc(1);
    endtask
    task automatic sh(input logic [4:0] val);
        shift_load_val <= val;
        shift_load <= 1'b1;
        cyc(1);
        shift_load <= 1'b0;
        cyc(1);
    endtask
    task automatic final_report();
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            n = notes.pop_front();
            check("reg_rdata", reg_rdata & n.m, n.e & n.m);
        end
        rd_seen <= reg_rd;
    end
    initial begin
        cyc(5000);
        fails++;
        final_report();
    end
    initial begin
        cyc(20);
        rst <= 1'b0;
        cyc(1);
        rd(afc_pkg::ADDR_FLAGS, afc_pkg::FLAGS_RESET, 16'hffff);
        rd(afc_pkg::ADDR_CTRL, afc_pkg::CTRL_RESET, 16'hffff);
        rd(afc_pkg::ADDR_SHIFT, {11'h000, afc_pkg::SHIFT_RESET}, 16'hffff);
        rd(2'h3, 16'h0000, 16'hffff);
        wr(afc_pkg::ADDR_CTRL, 16'hffff);
        rd(afc_pkg::ADDR_CTRL, 16'he0ff, 16'hffff);
        irq_active <= 1'b1;
        result_word <= seed;
        cyc(2);
        check("holds", {hold_imag_product, hold_real_product,
            hold_mult_inputs}, 3'b111);
        check("ctrl_out", ctrl_out, 10'h3ff);
        check("mode_out", mode_out, 2'h0);
        check("data msb", data_path_out, seed[31:8]);
        check("acc real", acc_pair_second, 1'b1);
        irq_active <= 1'b0;
        cyc(2);
        check("holds off", {hold_imag_product, hold_real_product,
            hold_mult_inputs}, 3'b000);
        sh(5'h10);
        sh(5'h18);
        check("shift min", shift_amount_reg, 5'h10);
        for (int k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            v = {seed[15:10], 2'(k % 3), seed[7:0]};
            wr(afc_pkg::ADDR_CTRL, v);
            rd(afc_pkg::ADDR_CTRL, v & afc_pkg::CTRL_WMASK, 16'hffff);
        end
        wr(afc_pkg::ADDR_CTRL, 16'h0004);
        sh(5'h18);
        check("shift plain", shift_amount_reg, 5'h18);
        check("data lsb", data_path_out, {8'h00, result_word[15:0]});
        alu(32'h8000_0000, 32'h0, 4'b1010);
        rd(afc_pkg::ADDR_FLAGS, 16'ha740, 16'hafff);
        check("branch", branch_flags & 16'hafff, 16'ha740);
        alu(32'h0, 32'h0, 4'b0000);
        rd(afc_pkg::ADDR_FLAGS, 16'h0b40, 16'hafff);
        test_sticky <= 1'b1;
        cyc(1);
        test_sticky <= 1'b0;
        cyc(2);
        check("taken", taken, 1'b1);
        rd(afc_pkg::ADDR_FLAGS, 16'h0940, 16'hafff);
        test_early <= 1'b1;
        cyc(1);
        test_early <= 1'b0;
        cyc(2);
        rd(afc_pkg::ADDR_FLAGS, 16'h0840, 16'hafff);
        wr(afc_pkg::ADDR_CTRL, 16'h0104);
        cyc(1);
        check("acc complex_mode", acc_pair_second, 1'b0);
        check("mode complex_mode", mode_out, 2'h1);
        alu(32'h0, 32'h0000_8000, 4'b0101);
        rd(afc_pkg::ADDR_FLAGS, 16'h5640, 16'hfeff);
        alu(32'hffff_0000, 32'h1234_0000, 4'b0000);
        rd(afc_pkg::ADDR_FLAGS, 16'h0a40, 16'hfeff);
        mult_ovf <= 1'b1;
        cyc(1);
        mult_ovf <= 1'b0;
        cyc(4);
        rd(afc_pkg::ADDR_FLAGS, 16'h0080, 16'h0080);
        load_flags_op <= 1'b1;
        cyc(1);
        load_flags_op <= 1'b0;
        fifo_empty <= 1'b0;
        cyc(2);
        rd(afc_pkg::ADDR_FLAGS, 16'h0000, 16'h00ff);
        cyc(3);
        final_report();
    end
endmodule
